// File: hw/cagen_pkg.sv
// package: constants and types for the address generation block
// Contract
// [RULE1] table call takes entry selected by opcode bits 1..5 from 40H..7FH
// [RULE2] register branch loads accumulator pair into program counter
// [RULE3] multiply takes A times X, product into accumulator pair
// [RULE4] word divide reads and writes accumulator pair implicitly
// [RULE5] decimal adjust and digit rotate operate on A implicitly
// [RULE6] register operand chosen by bank flags plus 3-bit code
// [RULE7] byte regs X,A,C,B,E,D,L,H = 0..7; pairs AX,BC,DE,HL = 0..3
// [RULE8] direct addressing uses full 16-bit immediate as address
// [RULE9] direct encoding: low address byte first, then high byte
// [RULE10] short direct reaches only FE20H..FF1FH with 8-bit offset
// [RULE11] short direct bit 8 is 1 for 00H..1FH, else 0; page FE00H
// [RULE12] software gives even addresses for word short direct operands
// [RULE13] special register address is FF00H plus 8-bit immediate
// [RULE14] software names only even 16-bit capable special registers
// [RULE15] register indirect uses named pair of selected bank as address
// [RULE16] based adds zero-extended offset to base pair, carry dropped
// [RULE17] based indexed adds B or C to base pair, carry dropped
// [RULE18] push, pop, call, return, interrupt save address via stack pointer; here only push and pop use sp_o, table call does not
// [RULE19] software keeps the stack in internal high-speed RAM
// [RULE20] table entry is low byte first at 40H plus twice index
// [RULE21] push predecrements stack pointer, pop postincrements it
package cagen_pkg;

  // ------------------------------------------------------------
  // address constants
  // ------------------------------------------------------------
  localparam logic [15:0] CAGEN_TABLE_BASE  = 16'h0040;
  localparam logic [15:0] CAGEN_SHORT_PAGE  = 16'hFE00;
  localparam logic [15:0] CAGEN_SFR_BASE    = 16'hFF00;
  localparam logic [7:0]  CAGEN_SHORT_SPLIT = 8'h20;
  localparam int          CAGEN_SHORT_BIT   = 8;
  localparam int          CAGEN_TIDX_LSB    = 1;
  localparam int          CAGEN_TIDX_MSB    = 5;
  localparam logic [15:0] CAGEN_PC_RESET    = 16'h0000;
  localparam logic [15:0] CAGEN_SP_RESET    = 16'hFF00;
  localparam logic [1:0]  CAGEN_BANK_RESET  = 2'h0;

  // ------------------------------------------------------------
  // register codes
  // ------------------------------------------------------------
  localparam logic [2:0] CAGEN_R_X = 3'h0;
  localparam logic [2:0] CAGEN_R_A = 3'h1;
  localparam logic [2:0] CAGEN_R_C = 3'h2;
  localparam logic [2:0] CAGEN_R_B = 3'h3;
  localparam logic [2:0] CAGEN_R_L = 3'h6;
  localparam logic [2:0] CAGEN_R_H = 3'h7;
  localparam logic [1:0] CAGEN_RP_ACC  = 2'h0;
  localparam logic [1:0] CAGEN_RP_BASE = 2'h3;

  // ------------------------------------------------------------
  // operation codes presented to the block
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    CAGEN_OP_NONE,
    CAGEN_OP_TABLE_CALL,
    CAGEN_OP_REG_BRANCH,
    CAGEN_OP_MULTIPLY,
    CAGEN_OP_DIVIDE,
    CAGEN_OP_ACC_IMPLIED,
    CAGEN_OP_REG,
    CAGEN_OP_DIRECT,
    CAGEN_OP_SHORT,
    CAGEN_OP_SFR,
    CAGEN_OP_REG_IND,
    CAGEN_OP_BASED,
    CAGEN_OP_BASED_IDX,
    CAGEN_OP_PUSH,
    CAGEN_OP_POP
  } cagen_op_t;

  // request from the decoder
  typedef struct packed {
    cagen_op_t   op;
    logic [7:0]  opcode;
    logic [7:0]  imm_low;
    logic [7:0]  imm_high;
    logic [2:0]  reg_code;
    logic [1:0]  pair_code;
    logic        index_b;
  } cagen_req_t;

  // operand answer
  typedef struct packed {
    logic        mem_valid;
    logic [15:0] mem_addr;
    logic        reg_valid;
    logic        reg_word;
    logic [4:0]  reg_index;
    logic        dst_valid;
    logic        dst_word;
    logic [4:0]  dst_index;
  } cagen_opnd_t;

endpackage : cagen_pkg

// File: hw/cagen_core.sv
// address generation for branch targets and operand effective addresses
`timescale 1ns/10ps
module cagen_core
(
  // clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_i,
  input  wire logic                   clk_en_i,
  // bank select flags
  input  wire logic                   bank_select_low_i,
  input  wire logic                   bank_select_high_i,
  // decoder request
  input  wire logic                   req_valid_i,
  input  wire cagen_pkg::cagen_req_t  req_i,
  // register file reads of selected bank
  input  wire logic [15:0]            rf_pair_i,
  input  wire logic [15:0]            rf_base_pair_i,
  input  wire logic [7:0]             rf_index_i,
  input  wire logic [15:0]            acc_pair_i,
  // table entry fetch data
  input  wire logic [15:0]            table_data_i,
  // program counter and stack pointer state
  output logic [15:0]                 pc_o,
  output logic [15:0]                 sp_o,
  output logic                        pc_load_o,
  // register file select
  output logic [4:0]                  rf_pair_sel_o,
  output logic [4:0]                  rf_base_sel_o,
  output logic [4:0]                  rf_index_sel_o,
  // table fetch address
  output logic [15:0]                 table_addr_o,
  // operand answer
  output logic                        opnd_valid_o,
  output cagen_pkg::cagen_opnd_t      opnd_o
);
  import cagen_pkg::*;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // absolute byte register index within bank
  function automatic logic [4:0] byte_index(input logic [1:0] bank,
                                             input logic [2:0] code);
    byte_index = {bank, code};
  endfunction : byte_index

  // pair index: low byte register of pair
  function automatic logic [4:0] pair_index(input logic [1:0] bank,
                                             input logic [1:0] code);
    pair_index = {bank, code, 1'b0};
  endfunction : pair_index

  // 16-bit add of zero-extended byte, carry dropped
  function automatic logic [15:0] add_byte(input logic [15:0] base,
                                            input logic [7:0]  offs);
    logic [16:0] sum;
    sum      = {1'b0, base} + {9'h000, offs};
    add_byte = sum[15:0];
  endfunction : add_byte

  // ------------------------------------------------------------
  // combinational address forming
  // ------------------------------------------------------------
  logic [1:0]  bank;
  logic [4:0]  tidx;
  logic [15:0] short_addr;
  logic [15:0] direct_addr;
  logic [15:0] sfr_addr;
  logic [7:0]  idx_code;

  assign bank = {bank_select_high_i, bank_select_low_i};
  assign tidx = req_i.opcode[CAGEN_TIDX_MSB:CAGEN_TIDX_LSB]; // [RULE1]
  // entry address = 40H + 2*index, low byte first
  assign table_addr_o = CAGEN_TABLE_BASE + {10'h000, tidx, 1'b0}; // [RULE20]
  assign direct_addr  = {req_i.imm_high, req_i.imm_low}; // [RULE8] [RULE9]
  // page FE00H, bit 8 set below split
  assign short_addr = CAGEN_SHORT_PAGE
                    | {7'h00,
                       (req_i.imm_low < CAGEN_SHORT_SPLIT),
                       req_i.imm_low}; // [RULE10] [RULE11]
  assign sfr_addr = CAGEN_SFR_BASE | {8'h00, req_i.imm_low}; // [RULE13]
  assign idx_code = {5'h00, (req_i.index_b ? CAGEN_R_B : CAGEN_R_C)};

  assign rf_pair_sel_o  = pair_index(bank, req_i.pair_code); // [RULE15]
  assign rf_base_sel_o  = pair_index(bank, CAGEN_RP_BASE); // [RULE16]
  assign rf_index_sel_o = byte_index(bank, idx_code[2:0]); // [RULE17]

  // ------------------------------------------------------------
  // operand answer register
  // ------------------------------------------------------------
  cagen_opnd_t opnd_next;
  logic        sp_dec;
  logic        sp_inc;

  always_comb
  begin
    opnd_next = '0;
    sp_dec    = 1'b0;
    sp_inc    = 1'b0;
    case (req_i.op)
      CAGEN_OP_MULTIPLY:
      begin
        opnd_next.reg_valid = 1'b1; // [RULE3]
        opnd_next.reg_index = byte_index(bank, CAGEN_R_X);
        opnd_next.dst_valid = 1'b1;
        opnd_next.dst_word  = 1'b1;
        opnd_next.dst_index = pair_index(bank, CAGEN_RP_ACC);
      end
      CAGEN_OP_DIVIDE:
      begin
        opnd_next.reg_valid = 1'b1; // [RULE4]
        opnd_next.reg_word  = 1'b1;
        opnd_next.reg_index = pair_index(bank, CAGEN_RP_ACC);
        opnd_next.dst_valid = 1'b1;
        opnd_next.dst_word  = 1'b1;
        opnd_next.dst_index = pair_index(bank, CAGEN_RP_ACC);
      end
      CAGEN_OP_ACC_IMPLIED:
      begin
        opnd_next.dst_valid = 1'b1; // [RULE5]
        opnd_next.dst_index = byte_index(bank, CAGEN_R_A);
      end
      CAGEN_OP_REG:
      begin
        opnd_next.reg_valid = 1'b1; // [RULE6] [RULE7]
        opnd_next.reg_index = byte_index(bank, req_i.reg_code);
      end
      CAGEN_OP_DIRECT:
      begin
        opnd_next.mem_valid = 1'b1; // [RULE8]
        opnd_next.mem_addr  = direct_addr;
      end
      CAGEN_OP_SHORT:
      begin
        opnd_next.mem_valid = 1'b1; // [RULE10]
        opnd_next.mem_addr  = short_addr;
      end
      CAGEN_OP_SFR:
      begin
        opnd_next.mem_valid = 1'b1; // [RULE13]
        opnd_next.mem_addr  = sfr_addr;
      end
      CAGEN_OP_REG_IND:
      begin
        opnd_next.mem_valid = 1'b1; // [RULE15]
        opnd_next.mem_addr  = rf_pair_i;
      end
      CAGEN_OP_BASED:
      begin
        opnd_next.mem_valid = 1'b1; // [RULE16]
        opnd_next.mem_addr  = add_byte(rf_base_pair_i, req_i.imm_low);
      end
      CAGEN_OP_BASED_IDX:
      begin
        opnd_next.mem_valid = 1'b1;
        opnd_next.mem_addr  = add_byte(rf_base_pair_i, rf_index_i); // [RULE17]
      end
      CAGEN_OP_PUSH:
      begin
        opnd_next.mem_valid = 1'b1; // [RULE18] [RULE21]
        opnd_next.mem_addr  = sp_o - 16'h0001;
        sp_dec              = 1'b1;
      end
      CAGEN_OP_POP:
      begin
        opnd_next.mem_valid = 1'b1; // [RULE18] [RULE21]
        opnd_next.mem_addr  = sp_o;
        sp_inc              = 1'b1;
      end
      default:
      begin
        opnd_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      opnd_valid_o <= 1'b0;
      opnd_o       <= '0;
    end
    else if (clk_en_i)
    begin
      opnd_valid_o <= req_valid_i;
      opnd_o       <= req_valid_i ? opnd_next : '0;
    end
  end

  // ------------------------------------------------------------
  // stack pointer
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      sp_o <= CAGEN_SP_RESET;
    else if (clk_en_i && req_valid_i && sp_dec)
      sp_o <= sp_o - 16'h0001; // [RULE21]
    else if (clk_en_i && req_valid_i && sp_inc)
      sp_o <= sp_o + 16'h0001; // [RULE21]
  end

  // ------------------------------------------------------------
  // program counter branch loads
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      pc_o      <= CAGEN_PC_RESET;
      pc_load_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      pc_load_o <= 1'b0;
      if (req_valid_i && req_i.op == CAGEN_OP_TABLE_CALL)
      begin
        pc_o      <= table_data_i; // [RULE1]
        pc_load_o <= 1'b1;
      end
      else if (req_valid_i && req_i.op == CAGEN_OP_REG_BRANCH)
      begin
        pc_o      <= acc_pair_i; // [RULE2]
        pc_load_o <= 1'b1;
      end
    end
  end

endmodule : cagen_core

// File: sim/cagen_core_props.sv
// checker for the address generator ports
`timescale 1ns/10ps
module cagen_core_props
  import cagen_pkg::*;
(
  // clock and reset
  input wire logic                  clk_sys_i,
  input wire logic                  reset_i,
  input wire logic                  clk_en_i,
  // request side
  input wire logic                  req_valid_i,
  input wire cagen_pkg::cagen_req_t req_i,
  input wire logic [15:0]           rf_base_pair_i,
  input wire logic [15:0]           acc_pair_i,
  input wire logic [15:0]           table_data_i,
  // answer side
  input wire logic [15:0]           pc_o,
  input wire logic [15:0]           sp_o,
  input wire logic                  pc_load_o,
  input wire logic [15:0]           table_addr_o,
  input wire cagen_pkg::cagen_opnd_t opnd_o
);
  logic tk;
  assign tk = clk_en_i && req_valid_i;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  a_short_page:
    assert property (tk && req_i.op == CAGEN_OP_SHORT |=> opnd_o.mem_addr ==
      {7'h7F, $past(req_i.imm_low) < 8'h20, $past(req_i.imm_low)})
    else $error("short direct address wrong");
  a_direct_word:
    assert property (tk && req_i.op == CAGEN_OP_DIRECT |=> opnd_o.mem_addr ==
      {$past(req_i.imm_high), $past(req_i.imm_low)})
    else $error("direct address wrong");
  a_sfr_page:
    assert property (tk && req_i.op == CAGEN_OP_SFR |=>
      opnd_o.mem_addr == {8'hFF, $past(req_i.imm_low)})
    else $error("special register address wrong");
  a_table_fetch:
    assert property (tk && req_i.op == CAGEN_OP_TABLE_CALL |->
      table_addr_o == 16'h0040 + {10'h0, req_i.opcode[5:1], 1'b0})
    else $error("table entry address wrong");
  a_table_load:
    assert property (tk && req_i.op == CAGEN_OP_TABLE_CALL |=>
      pc_load_o && pc_o == $past(table_data_i))
    else $error("table call target wrong");
  a_branch_load:
    assert property (tk && req_i.op == CAGEN_OP_REG_BRANCH |=>
      pc_load_o && pc_o == $past(acc_pair_i))
    else $error("register branch target wrong");
  a_based_sum:
    assert property (tk && req_i.op == CAGEN_OP_BASED |=> opnd_o.mem_addr ==
      $past(rf_base_pair_i) + {8'h00, $past(req_i.imm_low)})
    else $error("based address wrong");
  a_push_pre:
    assert property (tk && req_i.op == CAGEN_OP_PUSH |=>
      sp_o == $past(sp_o) - 16'h0001 && opnd_o.mem_addr == sp_o)
    else $error("push address wrong");
  a_pop_post:
    assert property (tk && req_i.op == CAGEN_OP_POP |=>
      sp_o == $past(sp_o) + 16'h0001 && opnd_o.mem_addr == $past(sp_o))
    else $error("pop address wrong");
  c_push: cover property (tk && req_i.op == CAGEN_OP_PUSH);
  c_table: cover property (tk && req_i.op == CAGEN_OP_TABLE_CALL);
  c_short: cover property (tk && req_i.op == CAGEN_OP_SHORT);
endmodule : cagen_core_props

// File: sim/cagen_rf_model.sv
// register file and call table model
`timescale 1ns/10ps
module cagen_rf_model
(
  // selects
  input  wire logic [1:0]  bank_i,
  input  wire logic [4:0]  pair_sel_i,
  input  wire logic [4:0]  base_sel_i,
  input  wire logic [4:0]  index_sel_i,
  input  wire logic [15:0] table_addr_i,
  // read data
  output logic [15:0]      pair_o,
  output logic [15:0]      base_o,
  output logic [7:0]       index_o,
  output logic [15:0]      acc_o,
  output logic [15:0]      table_o
);
  function automatic logic [7:0] rb(input logic [4:0] i);
    return 8'hE0 | {3'h0, i};
  endfunction : rb
  assign pair_o  = {rb(pair_sel_i + 5'h01), rb(pair_sel_i)};
  assign base_o  = {rb(base_sel_i + 5'h01), rb(base_sel_i)};
  assign index_o = rb(index_sel_i);
  assign acc_o   = {rb({bank_i, 3'h1}), rb({bank_i, 3'h0})};
  // entry word, low byte at even address
  assign table_o = {table_addr_i[7:0] ^ 8'h5A, table_addr_i[7:0]};
endmodule : cagen_rf_model

// File: sim/tb.sv
// testbench for the address generator
`timescale 1ns/10ps
module tb;
  import cagen_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [1:0] bank = 2'h0;
  logic vld = 1'b0;
  logic en = 1'b1;
  cagen_req_t req = '0;
  logic [15:0] pr, bp, acc, tbl, pc, sp, ta, ta_s;
  logic [7:0] ix;
  logic pl, ov;
  logic [4:0] ps, bs, isel, ps_s, is_s;
  cagen_opnd_t od;
  int err_count = 0;
  int num_checks = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  cagen_core i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .clk_en_i(en),
    .bank_select_low_i(bank[0]), .bank_select_high_i(bank[1]),
    .req_valid_i(vld), .req_i(req), .rf_pair_i(pr), .rf_base_pair_i(bp),
    .rf_index_i(ix), .acc_pair_i(acc), .table_data_i(tbl), .pc_o(pc),
    .sp_o(sp), .pc_load_o(pl), .rf_pair_sel_o(ps), .rf_base_sel_o(bs),
    .rf_index_sel_o(isel), .table_addr_o(ta), .opnd_valid_o(ov),
    .opnd_o(od));
  cagen_rf_model i_rf (.bank_i(bank), .pair_sel_i(ps), .base_sel_i(bs),
    .index_sel_i(isel), .table_addr_i(ta), .pair_o(pr), .base_o(bp),
    .index_o(ix), .acc_o(acc), .table_o(tbl));
  // ----
  // shared tasks
  // ----
  task automatic chk(input string n, input logic [15:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic send(input cagen_op_t op, input logic [7:0] oc, lo, hi,
                      input logic [2:0] rc, input logic [1:0] pc2,
                      input logic ib);
    @(posedge clk_sys_i);
    vld <= 1'b1;
    req <= '{op, oc, lo, hi, rc, pc2, ib};
    #1;
    ta_s = ta;
    ps_s = ps;
    is_s = isel;
    @(posedge clk_sys_i);
    vld <= 1'b0;
    #1;
    chk("valid", 16'(ov), 16'h0001);
  endtask : send
  task automatic wrap_up;
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // ----
  // scenarios
  // ----
  task automatic t_stack;
    send(CAGEN_OP_PUSH, 8'h00, 8'h00, 8'h00, 3'h0, 2'h0, 1'b0);
    chk("push sp", sp, 16'hFEFF);
    chk("push addr", od.mem_addr, 16'hFEFF);
    chk("push vld", 16'(od.mem_valid), 16'h0001);
    send(CAGEN_OP_POP, 8'h00, 8'h00, 8'h00, 3'h0, 2'h0, 1'b0);
    chk("pop addr", od.mem_addr, 16'hFEFF);
    chk("pop sp", sp, 16'hFF00);
  endtask : t_stack
  task automatic t_freeze;
    @(posedge clk_sys_i);
    en  <= 1'b0;
    vld <= 1'b1;
    req <= '{CAGEN_OP_PUSH, 8'h00, 8'h00, 8'h00, 3'h0, 2'h0, 1'b0};
    @(posedge clk_sys_i);
    en  <= 1'b1;
    vld <= 1'b0;
    #1;
    chk("frz sp", sp, 16'hFF00);
    chk("frz vld", 16'(ov), 16'h0000);
  endtask : t_freeze
  task automatic t_direct;
    logic [7:0] v [4] = '{8'h00, 8'h1E, 8'h20, 8'hFE};
    foreach (v[k])
    begin
      send(CAGEN_OP_SHORT, 8'h00, v[k], 8'h00, 3'h0, 2'h0, 1'b0);
      chk("short", od.mem_addr, {7'h7F, v[k] < 8'h20, v[k]});
      send(CAGEN_OP_SFR, 8'h00, v[k] | 8'hE0, 8'h00, 3'h0, 2'h0, 1'b0);
      chk("sfr", od.mem_addr, {8'hFF, v[k] | 8'hE0});
    end
    send(CAGEN_OP_DIRECT, 8'h00, 8'h00, 8'hFE, 3'h0, 2'h0, 1'b0);
    chk("direct", od.mem_addr, 16'hFE00);
  endtask : t_direct
  task automatic t_branch;
    logic [7:0] oc [2] = '{8'hC1, 8'h3E};
    logic [15:0] ex [2] = '{16'h1A40, 16'h247E};
    @(posedge clk_sys_i);
    bank <= 2'h2;
    foreach (oc[k])
    begin
      send(CAGEN_OP_TABLE_CALL, oc[k], 8'h00, 8'h00, 3'h0, 2'h0, 1'b0);
      chk("tbl addr", ta_s, 16'h0040 + {oc[k][5:1], 1'b0});
      chk("tbl pc", pc, ex[k]);
      chk("tbl load", 16'(pl), 16'h0001);
    end
    send(CAGEN_OP_REG_BRANCH, 8'h00, 8'h00, 8'h00, 3'h0, 2'h0, 1'b0);
    chk("br pc", pc, 16'hF1F0);
    chk("br load", 16'(pl), 16'h0001);
  endtask : t_branch
  task automatic t_indirect;
    @(posedge clk_sys_i);
    bank <= 2'h3;
    send(CAGEN_OP_BASED, 8'h00, 8'h10, 8'h00, 3'h0, 2'h0, 1'b0);
    chk("based", od.mem_addr, 16'h000E);
    send(CAGEN_OP_BASED_IDX, 8'h00, 8'h00, 8'h00, 3'h0, 2'h0, 1'b1);
    chk("idx sel", 16'(is_s), 16'(5'h1B));
    chk("idx", od.mem_addr, 16'h00F9);
    send(CAGEN_OP_REG_IND, 8'h00, 8'h00, 8'h00, 3'h0, 2'h1, 1'b0);
    chk("ind sel", 16'(ps_s), 16'(5'h1A));
    chk("ind", od.mem_addr, 16'hFBFA);
  endtask : t_indirect
  task automatic t_implied;
    @(posedge clk_sys_i);
    bank <= 2'h1;
    send(CAGEN_OP_MULTIPLY, 8'h00, 8'h00, 8'h00, 3'h0, 2'h0, 1'b0);
    chk("mul src", 16'(od.reg_index), 16'h0008);
    chk("mul dst", {od.dst_word, od.dst_index}, 16'h0028);
    send(CAGEN_OP_DIVIDE, 8'h00, 8'h00, 8'h00, 3'h0, 2'h0, 1'b0);
    chk("div dst", {od.dst_word, od.dst_index}, 16'h0028);
    chk("div src", {od.reg_word, od.reg_index}, 16'h0028);
    send(CAGEN_OP_ACC_IMPLIED, 8'h00, 8'h00, 8'h00, 3'h0, 2'h0, 1'b0);
    chk("acc dst", {od.dst_word, od.dst_index}, 16'h0009);
    send(CAGEN_OP_REG, 8'h00, 8'h00, 8'h00, 3'h7, 2'h0, 1'b0);
    chk("reg", 16'(od.reg_index), 16'h000F);
    send(CAGEN_OP_NONE, 8'h00, 8'h00, 8'h00, 3'h0, 2'h0, 1'b0);
    chk("none", 16'(od.mem_valid | od.reg_valid | od.dst_valid),
        16'h0000);
  endtask : t_implied
  initial
  begin
    #20000;
    err_count++;
    wrap_up();
  end
  initial
  begin
    repeat (2) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    #1;
    chk("rst sp", sp, 16'hFF00);
    t_stack();
    t_freeze();
    t_direct();
    t_branch();
    t_indirect();
    t_implied();
    wrap_up();
  end
endmodule : tb
bind cagen_core cagen_core_props i_props (.clk_sys_i(clk_sys_i),
  .reset_i(reset_i), .clk_en_i(clk_en_i), .req_valid_i(req_valid_i),
  .req_i(req_i), .rf_base_pair_i(rf_base_pair_i), .acc_pair_i(acc_pair_i),
  .table_data_i(table_data_i), .pc_o(pc_o), .sp_o(sp_o),
  .pc_load_o(pc_load_o), .table_addr_o(table_addr_o), .opnd_o(opnd_o));
